// ==== hdl/sac_ctrl.sv ====
// converter control top: APB registers, trigger, input sequencing, result buffer
// assumes the analog core holds its result stable while its done level is high
`timescale 1ns/100ps
`default_nettype none
module sac_ctrl
#(
	parameter logic [3:0] NEG_PIN = 4'h1
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extTrigPin,
	input wire logic timerEvent,
	input wire logic convDoneAsync,
	input wire logic [9:0] convResult,
	output logic convStart,
	output sac_pkg::sac_mux_s muxSel,
	output sac_pkg::sac_ref_s refSel,
	output logic offsetCalEn,
	output logic seqDone
);
	typedef enum logic [0:0] {ST_IDLE, ST_CONV} sac_state_e;

	logic [31:0] ctrl1_r, ctrl2_r, chsel_r, scan_r, prdata_r, rdData, fmtWord;
	logic pready_r, pslverr_r, rdHit, apbWrite, apbTake, convStart_r, seqDone_r;
	logic [11:0] regBase;
	logic [1:0] trigSync_r, doneSync_r;
	logic [9:0] resSync1_r, resSync2_r;
	logic trigSeen_r, doneSeen_r, trigEdge, doneEdge, trigNow, startNow;
	logic sampleDone, groupDone, useB, offsetCal_r, fillHalf_r, altB_r;
	logic [2:0] refCode, trigSrc;
	logic [3:0] seqPerGrp, smpCnt_r, wrPtr_r, wrIdx, scanCh_r, scanUse, posA, muxPos;
	logic [9:0] resBuf [16];
	sac_state_e state_r;
	sac_pkg::sac_mux_s muxSel_r, muxNow;
	sac_pkg::sac_ref_s refSel_r;

	if (NEG_PIN > 4'hF)
	begin : g_badPin
		$error("NEG_PIN out of range");
	end

	// ***********************
	// helpers
	// ***********************
	function automatic logic [31:0] aliasWr(input logic [31:0] cur, input logic [31:0] wd,
		input logic [1:0] op, input logic [31:0] msk);
		logic [31:0] v;
		v = cur;
		unique case (op)
			sac_pkg::ALIAS_WR: v = wd;
			sac_pkg::ALIAS_CLR: v = cur & ~wd;
			sac_pkg::ALIAS_SET: v = cur | wd;
			sac_pkg::ALIAS_INV: v = cur ^ wd;
		endcase
		return (v & msk) | (cur & ~msk);
	endfunction : aliasWr

	// next marked channel above cur, wrapping round; stays put if none other
	function automatic logic [3:0] nextScan(input logic [3:0] cur, input logic [15:0] msk);
		logic [3:0] n;
		logic [3:0] c;
		n = cur;
		for (int i = 15; i >= 1; i--)
		begin
			c = cur + 4'(i);
			if (msk[c])
				n = c;
		end
		return n;
	endfunction : nextScan

	assign refCode = ctrl2_r[sac_pkg::C2_REFSEL +: 3];
	assign seqPerGrp = ctrl2_r[sac_pkg::C2_SEQCNT +: 4];
	assign trigSrc = ctrl1_r[sac_pkg::C1_SSRC +: 3];

	// ***********************
	// APB slave
	// ***********************
	// one wait state: data is prepared in the first access cycle
	assign regBase = {paddr[11:4], 4'h0};
	assign apbTake = psel & penable & pready_r;
	assign apbWrite = apbTake & pwrite;

	sac_fmt u_fmt
	(
		.res(resBuf[paddr[5:2]]),
		.form(ctrl1_r[sac_pkg::C1_FORM +: 3]),
		.word(fmtWord)
	);

	always_comb
	begin
		rdData = 32'h00000000;
		rdHit = 1'b1;
		if (paddr[1:0] != 2'h0)
			rdHit = 1'b0;
		else if (paddr[11:6] == sac_pkg::OFS_BUF[11:6])
			rdData = pwrite ? 32'h00000000 : fmtWord;
		else
		begin
			case (regBase)
				sac_pkg::OFS_CTRL1: rdData = ctrl1_r;
				// upper half held zero by the write mask
				sac_pkg::OFS_CTRL2: rdData = {ctrl2_r[31:8], fillHalf_r, ctrl2_r[6:0]};
				sac_pkg::OFS_CHSEL: rdData = chsel_r;
				sac_pkg::OFS_SCAN: rdData = scan_r;
				default: rdHit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= psel & penable & ~pready_r;
			if (psel & penable & ~pready_r)
			begin
				prdata_r <= pwrite ? 32'h00000000 : rdData;
				pslverr_r <= ~rdHit;
			end
		end
	end

	// ***********************
	// control registers
	// ***********************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ctrl1_r <= sac_pkg::CTRL_RST;
		else
		begin
			if (startNow && trigSrc == sac_pkg::TRIG_MAN)
				ctrl1_r[sac_pkg::C1_SAMP] <= 1'b0;
			if (apbWrite && regBase == sac_pkg::OFS_CTRL1 && paddr[1:0] == 2'h0)
				ctrl1_r <= aliasWr(ctrl1_r, pwdata, paddr[3:2], sac_pkg::CTRL1_WMASK);
			// done flag: hardware set beats a software clear
			if (groupDone)
				ctrl1_r[sac_pkg::C1_DONE] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl2_r <= sac_pkg::CTRL_RST;
			chsel_r <= sac_pkg::CTRL_RST;
			scan_r <= sac_pkg::CTRL_RST;
		end
		else if (apbWrite && paddr[1:0] == 2'h0)
		begin
			if (regBase == sac_pkg::OFS_CTRL2)
				ctrl2_r <= aliasWr(ctrl2_r, pwdata, paddr[3:2], sac_pkg::CTRL2_WMASK);
			if (regBase == sac_pkg::OFS_CHSEL)
				chsel_r <= aliasWr(chsel_r, pwdata, paddr[3:2], sac_pkg::CHSEL_WMASK);
			if (regBase == sac_pkg::OFS_SCAN)
				scan_r <= aliasWr(scan_r, pwdata, paddr[3:2], sac_pkg::SCAN_WMASK);
		end
	end

	// ***********************
	// input synchronisers
	// ***********************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trigSync_r <= 2'h0;
			doneSync_r <= 2'h0;
			trigSeen_r <= 1'b0;
			doneSeen_r <= 1'b0;
			resSync1_r <= sac_pkg::RESULT_RST;
			resSync2_r <= sac_pkg::RESULT_RST;
		end
		else
		begin
			trigSync_r <= {trigSync_r[0], extTrigPin};
			doneSync_r <= {doneSync_r[0], convDoneAsync};
			trigSeen_r <= trigSync_r[1];
			doneSeen_r <= doneSync_r[1];
			resSync1_r <= convResult;
			resSync2_r <= resSync1_r;
		end
	end

	assign trigEdge = trigSync_r[1] & ~trigSeen_r;
	assign doneEdge = doneSync_r[1] & ~doneSeen_r;

	// ***********************
	// trigger and input selection
	// ***********************
	// pin edges arriving during a conversion are dropped, not queued
	// trigger source
	always_comb
	begin
		case (trigSrc)
			sac_pkg::TRIG_MAN: trigNow = ctrl1_r[sac_pkg::C1_SAMP];
			sac_pkg::TRIG_PIN: trigNow = trigEdge;
			sac_pkg::TRIG_TMR: trigNow = timerEvent;
			sac_pkg::TRIG_AUTO: trigNow = 1'b1;
			default: trigNow = 1'b0;
		endcase
	end

	assign startNow = state_r == ST_IDLE && ctrl1_r[sac_pkg::C1_ON] && trigNow;

	// skip to the next marked channel
	assign scanUse = scan_r[scanCh_r] ? scanCh_r : nextScan(scanCh_r, scan_r[15:0]);
	assign useB = ctrl2_r[sac_pkg::C2_ALTSAMP] & altB_r;
	assign posA = ctrl2_r[sac_pkg::C2_SCANSEL] ? scanUse : chsel_r[sac_pkg::CH_APOS +: 4];
	assign muxPos = useB ? chsel_r[sac_pkg::CH_BPOS +: 4] : posA;
	assign muxNow.pos = muxPos;
	// reference pin never its own differential partner
	assign muxNow.negRef = (useB ? chsel_r[sac_pkg::CH_BNEG] : chsel_r[sac_pkg::CH_ANEG])
		& (muxPos != NEG_PIN);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			convStart_r <= 1'b0;
			muxSel_r <= '0;
		end
		else
		begin
			convStart_r <= startNow;
			unique case (state_r)
				ST_IDLE:
					if (startNow)
					begin
						muxSel_r <= muxNow;
						state_r <= ST_CONV;
					end
				ST_CONV:
					if (doneEdge || !ctrl1_r[sac_pkg::C1_ON])
						state_r <= ST_IDLE;
			endcase
		end
	end

	// ***********************
	// reference select
	// ***********************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			refSel_r <= '0;
			offsetCal_r <= 1'b0;
		end
		else
		begin
			offsetCal_r <= ctrl2_r[sac_pkg::C2_OFFCAL];
			if (refCode[2] || refCode == sac_pkg::REF_RAILS)
				refSel_r <= '0;
			else
			begin
				refSel_r.highExt <= refCode == sac_pkg::REF_BOTH_EXT
					|| refCode == sac_pkg::REF_HIGH_EXT;
				refSel_r.lowExt <= refCode == sac_pkg::REF_BOTH_EXT
					|| refCode == sac_pkg::REF_LOW_EXT;
			end
		end
	end

	// ***********************
	// result buffer and sequencing
	// ***********************
	assign sampleDone = state_r == ST_CONV && doneEdge;
	// group of count plus one sequences
	assign groupDone = sampleDone && smpCnt_r == seqPerGrp;
	assign wrIdx = ctrl2_r[sac_pkg::C2_SPLIT] ? {fillHalf_r, wrPtr_r[2:0]} : wrPtr_r;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			smpCnt_r <= 4'h0;
			wrPtr_r <= 4'h0;
			fillHalf_r <= 1'b0;
			altB_r <= 1'b0;
			scanCh_r <= 4'h0;
			seqDone_r <= 1'b0;
			for (int i = 0; i < 16; i++)
				resBuf[i] <= sac_pkg::RESULT_RST;
		end
		else
		begin
			seqDone_r <= groupDone;
			if (sampleDone)
			begin
				resBuf[wrIdx] <= resSync2_r;
				altB_r <= ctrl2_r[sac_pkg::C2_ALTSAMP] & ~altB_r;
				if (ctrl2_r[sac_pkg::C2_SCANSEL] && !useB)
					scanCh_r <= nextScan(scanUse, scan_r[15:0]);
				if (groupDone)
				begin
					smpCnt_r <= 4'h0;
					wrPtr_r <= 4'h0;
					if (ctrl2_r[sac_pkg::C2_SPLIT])
						fillHalf_r <= ~fillHalf_r;
				end
				else
				begin
					smpCnt_r <= smpCnt_r + 4'h1;
					wrPtr_r <= wrPtr_r + 4'h1;
				end
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign convStart = convStart_r;
	assign muxSel = muxSel_r;
	assign refSel = refSel_r;
	assign offsetCalEn = offsetCal_r;
	assign seqDone = seqDone_r;

	// ***********************
	// checks
	// ***********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence sGroupEnd;
		sampleDone && smpCnt_r == seqPerGrp;
	endsequence

	a_ctrl2_upper_zero: assert property (psel && penable && !pready_r && !pwrite
		&& paddr == sac_pkg::OFS_CTRL2 |=> pready_r && prdata_r[31:16] == 16'h0000)
		else $error("control two upper half not zero");
	a_ref_both_ext: assert property (refCode == sac_pkg::REF_BOTH_EXT
		|=> refSel_r.highExt && refSel_r.lowExt)
		else $error("both external references not selected");
	a_ref_rails_def: assert property (refCode == sac_pkg::REF_RAILS
		|=> !refSel_r.highExt && !refSel_r.lowExt)
		else $error("code zero must select rails");
	a_group_done: assert property (sGroupEnd |=> seqDone_r ##1 !seqDone_r)
		else $error("group done pulse wrong");
	a_wrptr_step: assert property (sampleDone && !groupDone
		|=> wrPtr_r == $past(wrPtr_r) + 4'h1)
		else $error("write pointer did not advance");
	a_half_toggle: assert property (sGroupEnd ##0 ctrl2_r[sac_pkg::C2_SPLIT]
		|=> fillHalf_r != $past(fillHalf_r))
		else $error("fill half did not toggle");
	a_set_a_only: assert property (convStart_r && !ctrl2_r[sac_pkg::C2_ALTSAMP]
		&& !ctrl2_r[sac_pkg::C2_SCANSEL] |-> muxSel_r.pos == chsel_r[3:0])
		else $error("set A not used");
	a_scan_member: assert property (convStart_r && ctrl2_r[sac_pkg::C2_SCANSEL]
		&& !ctrl2_r[sac_pkg::C2_ALTSAMP] && scan_r[15:0] != 16'h0000
		|-> scan_r[muxSel_r.pos])
		else $error("unmarked channel converted");
	a_auto_start: assert property (state_r == ST_IDLE && ctrl1_r[sac_pkg::C1_ON]
		&& trigSrc == sac_pkg::TRIG_AUTO |=> convStart_r)
		else $error("auto trigger did not start");
	a_alias_set: assert property (apbWrite && paddr == sac_pkg::OFS_SCAN + 12'h008
		|=> (scan_r[15:0] & $past(pwdata[15:0])) == $past(pwdata[15:0]))
		else $error("set alias lost bits");
	a_ref_pin_excl: assert property (convStart_r
		|-> !(muxSel_r.negRef && muxSel_r.pos == NEG_PIN))
		else $error("reference pin used differentially");
endmodule : sac_ctrl
`default_nettype wire

// ==== hdl/sac_pkg.sv ====
// converter control package: register map, field layout, codes and carriers
// assumes a 32-bit APB slave with byte addresses on a 12-bit paddr
package sac_pkg;

	// ***********************
	// register map
	// ***********************
	localparam logic [11:0] OFS_CTRL1 = 12'h000;
	localparam logic [11:0] OFS_CTRL2 = 12'h010;
	localparam logic [11:0] OFS_CHSEL = 12'h020;
	localparam logic [11:0] OFS_SCAN = 12'h030;
	localparam logic [11:0] OFS_BUF = 12'h040;
	localparam logic [1:0] ALIAS_WR = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;

	// ***********************
	// writable bits and reset values
	// ***********************
	localparam logic [31:0] CTRL1_WMASK = 32'h000087E3;
	localparam logic [31:0] CTRL2_WMASK = 32'h0000F43F;
	localparam logic [31:0] CHSEL_WMASK = 32'h008F008F;
	localparam logic [31:0] SCAN_WMASK = 32'h0000FFFF;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [9:0] RESULT_RST = 10'h000;

	// ***********************
	// field positions
	// ***********************
	localparam int C1_ON = 15;
	localparam int C1_FORM = 8;
	localparam int C1_SSRC = 5;
	localparam int C1_SAMP = 1;
	localparam int C1_DONE = 0;
	localparam int C2_REFSEL = 13;
	localparam int C2_OFFCAL = 12;
	localparam int C2_SCANSEL = 10;
	localparam int C2_FILLHALF = 7;
	localparam int C2_SEQCNT = 2;
	localparam int C2_SPLIT = 1;
	localparam int C2_ALTSAMP = 0;
	localparam int CH_APOS = 0;
	localparam int CH_ANEG = 7;
	localparam int CH_BPOS = 16;
	localparam int CH_BNEG = 23;

	// ***********************
	// codes
	// ***********************
	localparam logic [2:0] TRIG_MAN = 3'h0;
	localparam logic [2:0] TRIG_PIN = 3'h1;
	localparam logic [2:0] TRIG_TMR = 3'h2;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [2:0] REF_RAILS = 3'h0;
	localparam logic [2:0] REF_HIGH_EXT = 3'h1;
	localparam logic [2:0] REF_LOW_EXT = 3'h2;
	localparam logic [2:0] REF_BOTH_EXT = 3'h3;
	localparam logic [2:0] FMT_U32 = 3'h0;
	localparam logic [2:0] FMT_S32 = 3'h1;
	localparam logic [2:0] FMT_UFR32 = 3'h2;
	localparam logic [2:0] FMT_SFR32 = 3'h3;
	localparam logic [2:0] FMT_U16 = 3'h4;
	localparam logic [2:0] FMT_S16 = 3'h5;
	localparam logic [2:0] FMT_UFR16 = 3'h6;
	localparam logic [2:0] FMT_SFR16 = 3'h7;

	// ***********************
	// carriers
	// ***********************
	typedef struct packed {
		logic negRef;
		logic [3:0] pos;
	} sac_mux_s;

	typedef struct packed {
		logic highExt;
		logic lowExt;
	} sac_ref_s;

endpackage : sac_pkg

// ==== hdl/sac_fmt.sv ====
// result formatter: widens a 10-bit stored result to a 32-bit read word
// assumes the result is offset binary from the converter core
`timescale 1ns/100ps
`default_nettype none
module sac_fmt
(
	input wire logic [9:0] res,
	input wire logic [2:0] form,
	output logic [31:0] word
);
	logic [9:0] sgn;

	// midscale becomes zero for the signed forms
	assign sgn = {~res[9], res[8:0]};

	always_comb
	begin
		unique case (form)
			sac_pkg::FMT_U32: word = {22'h000000, res};
			sac_pkg::FMT_S32: word = {{22{sgn[9]}}, sgn};
			sac_pkg::FMT_UFR32: word = {res, 22'h000000};
			sac_pkg::FMT_SFR32: word = {sgn, 22'h000000};
			sac_pkg::FMT_U16: word = {22'h000000, res};
			sac_pkg::FMT_S16: word = {16'h0000, {6{sgn[9]}}, sgn};
			sac_pkg::FMT_UFR16: word = {16'h0000, res, 6'h00};
			sac_pkg::FMT_SFR16: word = {16'h0000, sgn, 6'h00};
		endcase
	end
endmodule : sac_fmt
`default_nettype wire

// ==== sim/sac_core_model.sv ====
// analog core stand-in: answers each start pulse with a result after a short or long wait
// assumes start is a one-cycle pulse and the select is held until the next start
`timescale 1ns/100ps
`default_nettype none
module sac_core_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic convStart,
	input wire sac_pkg::sac_mux_s muxSel,
	input wire logic slowMode,
	output logic convDoneAsync,
	output logic [9:0] convResult
);
	int cnt;
	logic [9:0] held;

	// the result code carries the selected input so the bench can tell channels apart
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			held <= 10'h000;
			convDoneAsync <= 1'b0;
			convResult <= 10'h3FF;
		end
		else if (convStart)
		begin
			cnt <= slowMode ? 30 : 9;
			held <= {muxSel.pos, 1'b0, muxSel.negRef, 4'hA};
			convDoneAsync <= 1'b0;
		end
		else if (cnt > 0)
		begin
			cnt <= cnt - 1;
			// result settles a cycle before done; once done falls it is garbage again
			if (cnt == 7)
				convResult <= held;
			if (cnt == 6)
				convDoneAsync <= 1'b1;
			if (cnt == 1)
			begin
				convDoneAsync <= 1'b0;
				convResult <= ~held;
			end
		end
	end
endmodule : sac_core_model
`default_nettype wire

// ==== sim/tb_sac_ctrl.sv ====
// bench for the converter control block: registers, triggers, scan, alternate, split buffer
// assumes the core model answers every start pulse of the block
`timescale 1ns/100ps
`default_nettype none
module tb_sac_ctrl;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, extTrigPin, timerEvent;
	logic convDoneAsync, convStart, offsetCalEn, seqDone, slowMode, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic [9:0] convResult;
	sac_pkg::sac_mux_s muxSel;
	sac_pkg::sac_ref_s refSel;
	sac_pkg::sac_mux_s seen[$];
	int errCount = 0;
	int samplesChecked = 0;
	int cyc = 0;
	int groups = 0;

	sac_ctrl dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extTrigPin(extTrigPin), .timerEvent(timerEvent), .convDoneAsync(convDoneAsync),
		.convResult(convResult), .convStart(convStart), .muxSel(muxSel), .refSel(refSel),
		.offsetCalEn(offsetCalEn), .seqDone(seqDone));
	sac_core_model core (.clk(clk), .resetn(resetn), .convStart(convStart), .muxSel(muxSel),
		.slowMode(slowMode), .convDoneAsync(convDoneAsync), .convResult(convResult));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (convStart === 1'b1)
			seen.push_back(muxSel);
		if (seqDone === 1'b1)
			groups <= groups + 1;
		if (cyc == 30000)
		begin
			errCount++;
			summarize();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [9:0] resOf(input logic [4:0] m);
		return {m[3:0], 1'b0, m[4], 4'hA};
	endfunction : resOf

	// signed forms are offset binary minus mid-scale
	function automatic logic [31:0] fmtOf(input logic [9:0] r, input logic [2:0] f);
		logic [9:0] s;
		s = {~r[9], r[8:0]};
		case (f)
			3'h1: return {{22{s[9]}}, s};
			3'h2: return {r, 22'h0};
			3'h3: return {s, 22'h0};
			3'h5: return {16'h0, {6{s[9]}}, s};
			3'h6: return {16'h0, r, 6'h0};
			3'h7: return {16'h0, s, 6'h0};
			default: return {22'h0, r};
		endcase
	endfunction : fmtOf

	function automatic logic [31:0] opOf(input logic [31:0] v, input int op, input logic [31:0] d);
		case (op)
			0: return d;
			1: return v & ~d;
			2: return v | d;
			default: return v ^ d;
		endcase
	endfunction : opOf

	task automatic check(input logic [31:0] seenVal, input logic [31:0] expVal);
		samplesChecked++;
		if (seenVal !== expVal)
		begin
			errCount++;
			$display("ERROR %0t: saw %h expected %h", $time, seenVal, expVal);
		end
	endtask : check

	task automatic summarize();
		$display("compares %0d, mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// request held until pready is seen high; one idle edge after so strobes never double up
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check(rd, e);
	endtask : rdChk

	task automatic conv(input logic [2:0] trig);
		slowMode <= rnd[0];
		if (trig == sac_pkg::TRIG_MAN)
			apb(sac_pkg::OFS_CTRL1 + 12'h008, 1'b1, 32'h00000002);
		else if (trig == sac_pkg::TRIG_PIN)
			extTrigPin <= 1'b1;
		else
			timerEvent <= 1'b1;
		@(posedge clk);
		timerEvent <= 1'b0;
		while (convDoneAsync !== 1'b1)
		begin
			@(posedge clk);
		end
		extTrigPin <= 1'b0;
		repeat (8) @(posedge clk);
		rnd = lfsr(rnd);
	endtask : conv

	task automatic nextTest(input string name);
		$display("test %s finished, %0d mismatches so far", name, errCount);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		seen.delete();
		groups = 0;
		@(posedge clk);
	endtask : nextTest

	initial
	begin
		int i, k, n;
		logic [15:0] msk;
		logic [3:0] a, b;
		logic [3:0] ch[$];
		logic [31:0] e;
		sac_pkg::sac_mux_s mx;
		static logic [11:0] base[3] = '{sac_pkg::OFS_CTRL2, sac_pkg::OFS_CHSEL, sac_pkg::OFS_SCAN};
		static logic [31:0] wm[3] = '{sac_pkg::CTRL2_WMASK, sac_pkg::CHSEL_WMASK,
			sac_pkg::SCAN_WMASK};
		static logic [2:0] trigs[3] = '{sac_pkg::TRIG_MAN, sac_pkg::TRIG_PIN, sac_pkg::TRIG_TMR};
		{resetn, psel, penable, pwrite, extTrigPin, timerEvent, slowMode} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rnd = 32'h0000AA9A;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 20; i++)
			rdChk(i < 4 ? 12'(i * 16) : 12'(48 + 4 * i), 32'h0);
		apb(sac_pkg::OFS_BUF, 1'b1, rnd);
		rdChk(sac_pkg::OFS_BUF, 32'h0);
		apb(12'hFF0, 1'b1, rnd);
		check({31'h0, err}, 32'h1);
		rdChk(12'hFF0, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			e = 32'h0;
			for (k = 0; k < 4; k++)
			begin
				apb(base[i] + 12'(4 * k), 1'b1, rnd);
				e = opOf(e, k, rnd) & wm[i];
				rnd = lfsr(rnd);
				rdChk(base[i], e);
			end
		end
		for (i = 0; i < 8; i++)
		begin
			apb(sac_pkg::OFS_CTRL2, 1'b1, (32'(i) << 13) | 32'h00001000);
			@(posedge clk);
			check({29'h0, refSel, offsetCalEn}, {29'h0, i == 1 || i == 3, i == 2 || i == 3, 1'b1});
		end
		nextTest("registers");
		apb(sac_pkg::OFS_CTRL2, 1'b1, 32'h00000008);
		for (i = 0; i < 3; i++)
		begin
			mx = rnd[4:0];
			if (mx.pos == 4'h1)
				mx.negRef = 1'b0;
			apb(sac_pkg::OFS_CHSEL, 1'b1, {24'h0, mx.negRef, 3'h0, mx.pos});
			apb(sac_pkg::OFS_CTRL1, 1'b1, 32'h00008000 | (32'(trigs[i]) << 5));
			conv(trigs[i]);
			check({27'h0, seen[i]}, {27'h0, mx});
			check(32'(groups), 32'(i == 2));
			rdChk(12'(64 + 4 * i), {22'h0, resOf(mx)});
		end
		apb(sac_pkg::OFS_CTRL1, 1'b0, 32'h0);
		check({31'h0, rd[0]}, 32'h1);
		for (i = 0; i < 8; i++)
		begin
			apb(sac_pkg::OFS_CTRL1, 1'b1, 32'h00008000 | (32'(i) << 8));
			rdChk(sac_pkg::OFS_BUF + 12'h008, fmtOf(resOf(mx), 3'(i)));
		end
		nextTest("conversions");
		msk = rnd[15:0] | 16'h8000;
		for (i = 0; i < 16; i++)
			if (msk[i])
				ch.push_back(4'(i));
		n = ch.size();
		apb(sac_pkg::OFS_SCAN, 1'b1, {16'h0, msk});
		apb(sac_pkg::OFS_CTRL2, 1'b1, 32'h00000400 | (32'(n - 1) << 2));
		apb(sac_pkg::OFS_CTRL1, 1'b1, 32'h00008000 | (32'(sac_pkg::TRIG_TMR) << 5));
		for (i = 0; i < n + 2; i++)
		begin
			conv(sac_pkg::TRIG_TMR);
			check({27'h0, seen[i]}, {28'h0, ch[i % n]});
		end
		check(32'(groups), 32'((n + 2) / n));
		for (i = 0; i < n; i++)
			rdChk(12'(64 + 4 * i), {22'h0, resOf({1'b0, ch[i]})});
		nextTest("scan");
		apb(sac_pkg::OFS_CTRL2, 1'b1, 32'h00000007);
		apb(sac_pkg::OFS_CTRL1, 1'b1, 32'h00008000 | (32'(sac_pkg::TRIG_TMR) << 5));
		for (k = 0; k < 2; k++)
		begin
			a = rnd[3:0];
			b = rnd[7:4];
			apb(sac_pkg::OFS_CHSEL, 1'b1, {12'h0, b, 12'h0, a});
			conv(sac_pkg::TRIG_TMR);
			conv(sac_pkg::TRIG_TMR);
			check({27'h0, seen[2 * k]}, {28'h0, a});
			check({27'h0, seen[2 * k + 1]}, {28'h0, b});
			apb(sac_pkg::OFS_CTRL2, 1'b0, 32'h0);
			check({31'h0, rd[7]}, 32'(k == 0));
			rdChk(12'(64 + 32 * k), {22'h0, resOf({1'b0, a})});
			rdChk(12'(68 + 32 * k), {22'h0, resOf({1'b0, b})});
		end
		nextTest("alternate");
		apb(sac_pkg::OFS_CTRL1, 1'b1, 32'h00008000 | (32'(sac_pkg::TRIG_AUTO) << 5));
		repeat (120) @(posedge clk);
		apb(sac_pkg::OFS_CTRL1 + 12'h004, 1'b1, 32'h00008000);
		@(posedge clk);
		n = seen.size();
		check(32'(n > 1), 32'h1);
		repeat (60) @(posedge clk);
		check(32'(seen.size()), 32'(n));
		nextTest("auto");
		summarize();
	end
endmodule : tb_sac_ctrl
`default_nettype wire
